// file: logic/rfb_bus_if.sv
// Bus carrier joining the master end and the slave end
`timescale 1ns/100ps
interface rfb_bus_if #(
	parameter int AW = 32,
	parameter int DW = 32
);
	logic [AW-1:0]   adr;
	logic [DW-1:0]   dat_m2s;
	logic [DW-1:0]   dat_s2m;
	logic [DW/8-1:0] sel;
	logic            we;
	logic            cyc;
	logic            stb;
	logic            ack;
	logic [2:0]      cti;
	logic [1:0]      bte;
	modport master (
		output adr, dat_m2s, sel, we, cyc, stb, cti, bte,
		input  dat_s2m, ack
	);
	modport slave (
		input  adr, dat_m2s, sel, we, cyc, stb, cti, bte,
		output dat_s2m, ack
	);
endinterface

// file: logic/rfb_master.sv
// Master end: issues one burst per user request
`timescale 1ns/100ps
module rfb_master #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Bus side
	rfb_bus_if.master          bus,
	// User request
	input  wire logic          req,
	input  wire logic          req_we,
	input  wire logic [AW-1:0] req_adr,
	input  wire logic [2:0]    req_cti,
	input  wire logic [1:0]    req_bte,
	input  wire logic [7:0]    req_len,
	input  wire logic [DW-1:0] wr_dat,
	input  wire logic          pause,
	// User answer
	output logic               rd_vld,
	output logic [DW-1:0]      rd_dat,
	output logic               idle
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} rfb_mst_st_t;

	rfb_mst_st_t   st_r;
	logic          cyc_r;
	logic          stb_r;
	logic          we_r;
	logic [AW-1:0] adr_r;
	logic [2:0]    cti_r;
	logic [1:0]    bte_r;
	logic [7:0]    left_r;
	logic [DW-1:0] dat_r;
	logic          vld_r;
	logic [DW-1:0] rdd_r;

	wire logic [AW-1:0] nxt_adr;
	rfb_next_adr #(.AW(AW), .DW(DW)) u_nxt (
		.adr (adr_r),
		.cti (cti_r),
		.bte (bte_r),
		.nxt (nxt_adr)
	);

	wire logic   done   = cyc_r && stb_r && bus.ack;
	wire logic   fin    = done && (left_r == 8'h01);
	wire logic   go     = (st_r == ST_IDLE) && req;
	// Single beats go out as end-of-burst straight away
	wire logic [2:0] cti0 = (req_len == 8'h01) ? rfb_pkg::CTI_EOB : req_cti;
	wire logic   to_eob = done && (left_r == 8'h02);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r   <= ST_IDLE;
			cyc_r  <= 1'b0;
			stb_r  <= 1'b0;
			we_r   <= 1'b0;
			adr_r  <= '0;
			cti_r  <= rfb_pkg::CTI_CLASSIC;
			bte_r  <= rfb_pkg::BTE_LINEAR;
			left_r <= rfb_pkg::RST_BEAT_CNT;
			dat_r  <= '0;
			vld_r  <= 1'b0;
			rdd_r  <= '0;
		end else begin
			vld_r <= done && !we_r;
			if (done) begin
				rdd_r <= bus.dat_s2m;
			end
			case (st_r)
				ST_IDLE: begin
					if (go && req_len != 8'h00) begin
						// All opening signals change on one edge, except stb, which stays low while pause is high
						st_r   <= ST_RUN;
						cyc_r  <= 1'b1;
						stb_r  <= !pause;
						we_r   <= req_we;
						adr_r  <= req_adr;
						cti_r  <= cti0;
						bte_r  <= req_bte;
						left_r <= req_len;
						dat_r  <= wr_dat;
					end
				end
				ST_RUN: begin
					if (fin) begin
						st_r  <= ST_IDLE;
						cyc_r <= 1'b0;
						stb_r <= 1'b0;
						cti_r <= rfb_pkg::CTI_CLASSIC;
					end else begin
						// Direction and select held; address steps or stays
						stb_r <= !pause;
						if (done) begin
							left_r <= left_r - 8'h01;
							adr_r  <= nxt_adr;
							dat_r  <= wr_dat;
							if (to_eob) begin
								cti_r <= rfb_pkg::CTI_EOB;
							end
						end
					end
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	assign bus.cyc     = cyc_r;
	assign bus.stb     = stb_r;
	assign bus.we      = we_r;
	assign bus.adr     = adr_r;
	assign bus.cti     = cti_r;
	assign bus.bte     = bte_r;
	assign bus.sel     = '1;
	assign bus.dat_m2s = dat_r;
	assign rd_vld      = vld_r;
	assign rd_dat      = rdd_r;
	assign idle        = st_r[0];
endmodule

// file: logic/rfb_next_adr.sv
// Next burst address: linear or wrapped increment
`timescale 1ns/100ps
module rfb_next_adr #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	// Current beat
	input  wire logic [AW-1:0] adr,
	input  wire logic [2:0]    cti,
	input  wire logic [1:0]    bte,
	// Following beat
	output logic [AW-1:0]      nxt
);
	localparam int          SH  = $clog2(DW/8);
	localparam logic [AW-1:0] INC = AW'(DW/8);
	wire logic [AW-1:0] lin  = adr + INC;
	wire logic [AW-1:0] w4m  = AW'(4 << SH) - AW'(1);
	wire logic [AW-1:0] w8m  = AW'(8 << SH) - AW'(1);
	wire logic [AW-1:0] w16m = AW'(16 << SH) - AW'(1);
	wire logic [AW-1:0] msk  = (bte == rfb_pkg::BTE_WRAP4) ? w4m :
	                           (bte == rfb_pkg::BTE_WRAP8) ? w8m :
	                           (bte == rfb_pkg::BTE_WRAP16) ? w16m : '1;
	// Wrap keeps the high bits and rolls only the low ones
	wire logic [AW-1:0] wrp  = (adr & ~msk) | (lin & msk);
	assign nxt = (cti == rfb_pkg::CTI_INCR) ? wrp : adr;
endmodule

// file: logic/rfb_pkg.sv
// Shared constants and types for the registered-feedback burst ends
package rfb_pkg;
	typedef enum logic [2:0] {
		CTI_CLASSIC = 3'h0,
		CTI_CONST   = 3'h1,
		CTI_INCR    = 3'h2,
		CTI_EOB     = 3'h7
	} rfb_cti_t;
	typedef enum logic [1:0] {
		BTE_LINEAR = 2'h0,
		BTE_WRAP4  = 2'h1,
		BTE_WRAP8  = 2'h2,
		BTE_WRAP16 = 2'h3
	} rfb_bte_t;
	localparam logic [7:0] RST_BEAT_CNT = 8'h00;
	localparam logic       RST_LEVEL    = 1'b0;
endpackage

// file: logic/rfb_slave.sv
// Slave end: registered-feedback burst responder over a small word memory
//
// Notes on behaviour
// - single access is a burst of one
// - master ends burst with code 111
// - on end-of-burst give last beat, drop ack
// - master may start new cycle on last edge
// - new cycle marked end-of-burst is single transfer
// - constant burst repeats the same address
// - constant burst keeps direction, select, address
// - slave acks next beat without wait cycle
// - one word per clock without waits
// - master stalls by dropping strobe
// - master resumes strobe, select, data together
// - slave stalls by dropping ack
// - unstalled burst keeps ack high each edge
// - increment equals data width in bytes
// - linear step is one increment
// - wrapped step rolls low bits modulo wrap
// - incrementing burst keeps direction, select, sets wrap
// - master opens burst with all signals together (rfb_master holds strobe low while pause is high)
// - final edge drops ack, cycle and strobe
// - cycle-type codes 000,001,010,111
// - burst-type codes linear, wrap 4/8/16
// - transfer completes on ack and strobe together
`timescale 1ns/100ps
module rfb_slave #(
	parameter int AW    = 32,
	parameter int DW    = 32,
	parameter int DEPTH = 64
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Bus side
	rfb_bus_if.slave   bus,
	// User side
	input  wire logic  hold,
	output logic       busy,
	output logic [7:0] beat_cnt
);
	localparam int SH = $clog2(DW/8);
	localparam int IW = $clog2(DEPTH);
	localparam int NL = DW/8;

	// Responder phase: idle, lone beat, burst with ack, burst stalled
	typedef enum logic [3:0] {
		SL_IDLE  = 4'b0001,
		SL_BEAT  = 4'b0010,
		SL_BURST = 4'b0100,
		SL_PAUSE = 4'b1000
	} rfb_slv_st_t;

	logic [DW-1:0] mem [DEPTH];
	rfb_slv_st_t   st_r;
	rfb_slv_st_t   st_nxt;
	logic          ack_r;
	logic [DW-1:0] dat_r;
	logic [AW-1:0] adr_r;
	logic          busy_r;
	logic [7:0]    cnt_r;

	wire logic [AW-1:0] nxt_adr;
	rfb_next_adr #(.AW(AW), .DW(DW)) u_nxt (
		.adr (adr_r),
		.cti (bus.cti),
		.bte (bus.bte),
		.nxt (nxt_adr)
	);

	// Tag decode; reserved codes match neither and run as classic
	wire logic is_const = (bus.cti == rfb_pkg::CTI_CONST);
	wire logic is_incr  = (bus.cti == rfb_pkg::CTI_INCR);
	wire logic is_burst = is_const || is_incr;
	// Open burst, whether the ack is up or held back
	wire logic in_burst = (st_r == SL_BURST) || (st_r == SL_PAUSE);

	// Beat completion and acknowledge sources
	wire logic done     = ack_r && bus.stb && bus.cyc;
	wire logic last     = done && !is_burst;
	// Fresh request: first beat of any cycle, bursts and single end-of-burst alike
	wire logic start    = bus.cyc && bus.stb && !ack_r && !hold;
	// Ack stays up after a burst beat, independent of strobe, so no wait state
	wire logic cont     = in_burst && bus.cyc && !last && !hold;
	wire logic ack_nxt  = (start || cont) && !last;
	wire logic stay     = bus.cyc && is_burst;
	wire logic step     = done && is_burst;
	wire logic [AW-1:0] use_adr = step ? nxt_adr : bus.adr;
	wire logic [IW-1:0] idx_nxt = use_adr[IW+SH-1:SH];
	wire logic [IW-1:0] idx_cur = bus.adr[IW+SH-1:SH];

	// Per-lane write strobes; only a completed beat may touch memory
	wire logic [NL-1:0] lane_we;
	for (genvar g = 0; g < NL; g++) begin : g_lane
		assign lane_we[g] = done && bus.we && bus.sel[g];
	end

	// Next phase; a burst stays open only while the tag still says burst
	always_comb begin
		st_nxt = SL_IDLE;
		case (st_r)
			SL_IDLE: begin
				if (start && is_burst) begin
					st_nxt = SL_BURST;
				end else if (start) begin
					st_nxt = SL_BEAT;
				end
			end
			SL_BEAT: begin
				// A lone beat closes after its one acknowledge
				st_nxt = SL_IDLE;
			end
			SL_BURST: begin
				if (stay && ack_nxt) begin
					st_nxt = SL_BURST;
				end else if (stay) begin
					st_nxt = SL_PAUSE;
				end else if (ack_nxt) begin
					st_nxt = SL_BEAT;
				end
			end
			SL_PAUSE: begin
				// Stalled burst resumes without a fresh strobe
				if (stay && ack_nxt) begin
					st_nxt = SL_BURST;
				end else if (stay) begin
					st_nxt = SL_PAUSE;
				end else if (ack_nxt) begin
					st_nxt = SL_BEAT;
				end
			end
			default: begin
				st_nxt = SL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= SL_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Ack is registered, so the master sees it change only on an edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_r <= rfb_pkg::RST_LEVEL;
		end else begin
			ack_r <= ack_nxt;
		end
	end

	// Busy only mirrors the cycle a clock late; it is a status, not a gate
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_r <= rfb_pkg::RST_LEVEL;
		end else begin
			busy_r <= bus.cyc;
		end
	end

	// Beats counted on completion only, so stalls do not inflate the count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= rfb_pkg::RST_BEAT_CNT;
		end else if (done) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Address of the word now on the read bus, source of the next step
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			adr_r <= '0;
		end else begin
			adr_r <= use_adr;
		end
	end

	// Prefetch the following word while this beat completes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dat_r <= '0;
		end else begin
			dat_r <= mem[idx_nxt];
		end
	end

	// Writes land only on a completed beat; byte lanes follow the select
	always_ff @(posedge clk) begin
		for (int b = 0; b < NL; b++) begin
			if (lane_we[b]) begin
				mem[idx_cur][b*8 +: 8] <= bus.dat_m2s[b*8 +: 8];
			end
		end
	end

	assign bus.ack     = ack_r;
	assign bus.dat_s2m = dat_r;
	assign busy        = busy_r;
	assign beat_cnt    = cnt_r;
endmodule

// file: tb/rfb_properties.sv
// Link assertions between the master and slave ends
`timescale 1ns/100ps
module rfb_properties (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [31:0] adr,
	input wire logic        we,
	input wire logic        cyc,
	input wire logic        stb,
	input wire logic        ack,
	input wire logic [2:0]  cti,
	input wire logic [1:0]  bte
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence beat; cyc && stb && ack; endsequence
	sequence ib(logic [1:0] b); beat ##0 cti == 3'h2 && bte == b; endsequence
	a_ack_cause: assert property ($rose(ack) |-> $past(cyc))
		else $error("ack rose without request");
	a_eob_end: assert property (beat ##0 cti == 3'h7 |=> !ack && !cyc)
		else $error("burst not closed");
	a_lin_step: assert property (ib(2'h0) |=> adr == $past(adr) + 32'h4)
		else $error("linear step wrong");
	a_wrap4_step: assert property (ib(2'h1) |=> adr[3:2] == $past(adr[3:2]) + 2'h1
		&& adr[31:4] == $past(adr[31:4])) else $error("wrap step wrong");
	a_const_same: assert property (beat ##0 cti == 3'h1 |=> adr == $past(adr))
		else $error("constant address moved");
	a_cti_legal: assert property (cyc |-> cti inside {3'h1, 3'h2, 3'h7})
		else $error("cycle type code");
	a_wait_hold: assert property (cyc && stb && !ack |=> cyc && $stable(adr))
		else $error("request not held");
	a_idle_ack: assert property (!cyc |=> !ack)
		else $error("ack outside cycle");
	a_burst_same: assert property (cyc ##1 cyc |-> $stable(we) && $stable(bte))
		else $error("direction or wrap changed");
endmodule

// file: tb/tb.sv
// Bench: random bursts written, read back and compared
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        req = 1'b0, req_we = 1'b0, hold = 1'b0, pause = 1'b0, stl = 1'b0;
	logic        rd_vld, idle, busy;
	logic [31:0] req_adr = '0, wr_dat = '0, s = 32'h11, q, r, rd_dat;
	logic [31:0] ea [67], d [67], mem [64];
	logic [2:0]  req_cti = 3'h2;
	logic [1:0]  req_bte = 2'h0;
	logic [7:0]  req_len = 8'h0, nb = 8'h0, beat_cnt;
	int          mismatches = 0, checks_done = 0, bi = 0, ri = 0;
	always #5 clk = ~clk;
	rfb_bus_if bus ();
	rfb_master u_rfb_master (.clk, .rst_n, .bus, .req, .req_we, .req_adr, .req_cti, .req_bte,
		.req_len, .wr_dat, .pause, .rd_vld, .rd_dat, .idle);
	rfb_slave u_rfb_slave (.clk, .rst_n, .bus, .hold, .busy, .beat_cnt);
	rfb_properties u_rfb_properties (.clk, .rst_n, .adr(bus.adr), .we(bus.we), .cyc(bus.cyc),
		.stb(bus.stb), .ack(bus.ack), .cti(bus.cti), .bte(bus.bte));
	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// Wrap mask spans 4, 8 or 16 words of 4 bytes
	function automatic logic [31:0] nx(logic [31:0] a, logic [2:0] c, logic [1:0] b);
		logic [31:0] m;
		m = (b == 2'h0) ? '1 : (32'h8 << b) - 32'h1;
		return (c == 3'h1) ? a : (a & ~m) | ((a + 32'h4) & m);
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic run(logic w, logic [31:0] a, logic [2:0] c, logic [1:0] b, logic [7:0] n);
		int k;
		ea[0] = a;
		for (k = 0; k < n; k++) begin
			d[k] = rnd();
			ea[k + 1] = nx(ea[k], c, b);
			if (w)
				mem[ea[k][7:2]] = d[k];
		end
		bi = 0;
		ri = 0;
		@(posedge clk);
		{req_we, req_adr, req_cti, req_bte, req_len, req, wr_dat} <= {w, a, c, b, n, 1'b1, d[0]};
		repeat (2) @(posedge clk);
		{req, wr_dat} <= {1'b0, d[1]};
		for (k = 0; k < 3000 && !(idle && bi >= n); k++)
			@(negedge clk);
		repeat (3) @(negedge clk);
		nb += n;
		chk(bi, n);
		chk(ri, w ? 0 : n);
		chk(beat_cnt, nb);
		chk(busy, 0);
		$display("test done");
	endtask
	// Stalls only inside cycles, so random draws never collide with the task's
	always @(posedge clk)
		if (bus.cyc && stl) begin
			q = rnd();
			{pause, hold} <= {&q[1:0], &q[3:2]};
		end else
			{pause, hold} <= 2'b0;
	// Next write word must be in place before the edge that completes a beat
	always @(posedge clk)
		if (bus.cyc && bus.stb && bus.ack) begin
			chk(bus.adr, ea[bi]);
			wr_dat <= d[bi + 2];
			bi <= bi + 1;
		end
	always @(posedge clk)
		if (rd_vld) begin
			chk(rd_dat, mem[ea[ri][7:2]]);
			ri <= ri + 1;
		end
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		run(1'b1, 32'h0, 3'h2, 2'h0, 8'h40);
		run(1'b0, 32'hf8, 3'h2, 2'h0, 8'h40);
		run(1'b1, 32'h14, 3'h2, 2'h0, 8'h1);
		for (int b = 0; b < 4; b++)
			run(1'b0, 32'h34, 3'h2, 2'(b), 8'h10);
		stl = 1'b1;
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			run(r[0], {24'h0, r[9:4], 2'h0}, r[1] ? 3'h2 : 3'h1, r[3:2], 8'(r[12:10]) + 8'h1);
		end
		end_sim();
	end
endmodule
